/* common/dpob_consts.vh */
// Object indices, field positions, reset values and timing counts
`ifndef DPOB_CONSTS_VH
`define DPOB_CONSTS_VH
`define DPOB_IDX_QSTOP 16'h604A
`define DPOB_IDX_MODE_SEL 16'h6060
`define DPOB_IDX_MODE_ECHO 16'h6061
`define DPOB_IDX_MEAS_POS 16'h6064
`define DPOB_IDX_TRK_BAND 16'h6065
`define DPOB_IDX_TRK_DELAY 16'h6066
`define DPOB_IDX_ARR_BAND 16'h6067
`define DPOB_IDX_ARR_DWELL 16'h6068
`define DPOB_IDX_TRQ_SET 16'h6071
`define DPOB_IDX_MEAS_TRQ 16'h6077
`define DPOB_IDX_MEAS_CUR 16'h6078
`define DPOB_IDX_BUS_MV 16'h6079
`define DPOB_IDX_GOAL_POS 16'h607A
`define DPOB_IDX_ZERO_SHIFT 16'h607C
`define DPOB_IDX_CRUISE 16'h6081
`define DPOB_IDX_RAMP_UP 16'h6083
`define DPOB_IDX_RAMP_DN 16'h6084
`define DPOB_QSTOP_MAX_SUB 8'h02
`define DPOB_DSPEED_MIN 32'h00000001
`define DPOB_DSPEED_MAX 32'h00007FFF
`define DPOB_DTIME_MIN 16'h0001
`define DPOB_DSPEED_RST 32'h00000001
`define DPOB_DTIME_RST 16'h0001
`define DPOB_MODE_PROFILE 8'h01
`define DPOB_MODE_VELOCITY 8'h02
`define DPOB_MODE_HOMING 8'h06
`define DPOB_MODE_INTERP 8'h07
`define DPOB_MODE_TABLE 8'hFF
`define DPOB_WIN_MAX 32'h7FFFFFFF
`define DPOB_WIN_OFF 32'hFFFFFFFF
`define DPOB_SW_TARGET_BIT 10
`define DPOB_SW_FOLLOW_BIT 13
`define DPOB_TRQ_RATED 16'h03E8
`define DPOB_CUR_RATED 16'h03E8
`define DPOB_SRC_TRQ_DIRECT 8'h5F
`define DPOB_SRC_TRQ_INVERT 8'hC3
`define DPOB_CLK_HZ 10000000
`define DPOB_MS_CYCLES (`DPOB_CLK_HZ / 1000)
`define DPOB_NV_IDLE 4'h1
`define DPOB_NV_SAVE 4'h2
`define DPOB_NV_LOAD 4'h4
`define DPOB_NV_DONE 4'h8
`define DPOB_NV_WORDS 11
`define DPOB_NV_LAST 4'hA
`endif

/* hdl/dpob_object_bank.v */
// Drive-profile object dictionary bank with position supervision
`timescale 1ns/10ps
`include "dpob_consts.vh"
module dpob_object_bank #(
  parameter MS_CYCLES = `DPOB_MS_CYCLES,
  parameter POLE_W = 8
) (
  input wire sys_clk,
  input wire reset,
  input wire clk_en,
  input wire obj_wr,
  input wire obj_rd,
  input wire [15:0] obj_index,
  input wire [7:0] obj_sub,
  input wire [31:0] obj_wdata,
  output reg [31:0] obj_rdata,
  output reg obj_ack,
  output reg obj_abort,
  input wire motion_cfg,
  input wire mode_taken,
  input wire save_cmd,
  input wire [POLE_W-1:0] pole_pairs,
  input wire [31:0] pos_demand,
  input wire [31:0] pos_actual,
  input wire [15:0] torque_pm,
  input wire [15:0] current_pm,
  input wire [31:0] bus_mv,
  output reg [31:0] estop_cw,
  output reg [31:0] estop_acw,
  output reg [7:0] mode_req,
  output reg [31:0] contour_warn,
  output reg [31:0] contour_time,
  output reg [31:0] target_window,
  output reg [31:0] target_win_time,
  output reg [31:0] home_offset,
  output reg [31:0] app_position,
  output reg [15:0] torque_ref,
  output reg [15:0] torque_ref_inv,
  output reg [15:0] status_bits,
  output reg nv_wr,
  output reg nv_rd,
  output reg [3:0] nv_addr,
  output reg [31:0] nv_wdata,
  input wire [31:0] nv_rdata,
  input wire nv_ready
);
  // ==========================================================
  // Object storage
  reg [31:0] dspeed_ff;
  reg [15:0] dtime_ff;
  reg [7:0] mode_sel_ff;
  reg [7:0] mode_echo_ff;
  reg [31:0] trk_band_ff;
  reg [31:0] trk_delay_ff;
  reg [31:0] arr_band_ff;
  reg [31:0] arr_dwell_ff;
  reg [15:0] trq_set_ff;
  reg [31:0] goal_ff;
  reg [31:0] zshift_ff;
  reg [31:0] cruise_ff;
  reg [31:0] rup_ff;
  reg [31:0] rdn_ff;
  reg [31:0] pos_dem_s1_ff;
  reg [31:0] pos_dem_s2_ff;
  reg [31:0] pos_act_s1_ff;
  reg [31:0] pos_act_s2_ff;
  reg mode_tk_s1_ff;
  reg mode_tk_s2_ff;
  reg motion_s1_ff;
  reg motion_s2_ff;
  reg [3:0] nv_st_ff;
  reg [3:0] nv_idx_ff;
  reg nv_wait_ff;
  reg [31:0] nv_word;

  wire wr_en = clk_en & obj_wr & (nv_st_ff == `DPOB_NV_IDLE);
  wire rd_en = clk_en & obj_rd;

  // ==========================================================
  // Range checks
  wire win_bad = obj_wdata[31] & (obj_wdata != `DPOB_WIN_OFF);
  wire dspeed_bad = (obj_wdata < `DPOB_DSPEED_MIN) |
    (obj_wdata > `DPOB_DSPEED_MAX);
  wire dtime_bad = (obj_wdata[15:0] < `DPOB_DTIME_MIN) |
    (obj_wdata[31:16] != 16'h0000);
  reg mode_ok;
  always @* begin
    if (motion_s2_ff) begin
      case (obj_wdata[7:0])
        `DPOB_MODE_PROFILE, `DPOB_MODE_VELOCITY, `DPOB_MODE_HOMING,
        `DPOB_MODE_INTERP, `DPOB_MODE_TABLE: mode_ok = 1'b1;
        default: mode_ok = 1'b0;
      endcase
    end else begin
      mode_ok = (obj_wdata[7:0] == `DPOB_MODE_VELOCITY);
    end
  end

  // ==========================================================
  // Synchronisers for pin-side inputs
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pos_dem_s1_ff <= 32'h00000000;
      pos_dem_s2_ff <= 32'h00000000;
      pos_act_s1_ff <= 32'h00000000;
      pos_act_s2_ff <= 32'h00000000;
      mode_tk_s1_ff <= 1'b0;
      mode_tk_s2_ff <= 1'b0;
      motion_s1_ff <= 1'b0;
      motion_s2_ff <= 1'b0;
    end else if (clk_en) begin
      pos_dem_s1_ff <= pos_demand;
      pos_dem_s2_ff <= pos_dem_s1_ff;
      pos_act_s1_ff <= pos_actual;
      pos_act_s2_ff <= pos_act_s1_ff;
      mode_tk_s1_ff <= mode_taken;
      mode_tk_s2_ff <= mode_tk_s1_ff;
      motion_s1_ff <= motion_cfg;
      motion_s2_ff <= motion_s1_ff;
    end
  end

  // ==========================================================
  // Non-volatile image word select
  always @* begin
    case (nv_idx_ff)
      4'h0: nv_word = dspeed_ff;
      4'h1: nv_word = {16'h0000, dtime_ff};
      4'h2: nv_word = trk_band_ff;
      4'h3: nv_word = trk_delay_ff;
      4'h4: nv_word = arr_band_ff;
      4'h5: nv_word = arr_dwell_ff;
      4'h6: nv_word = zshift_ff;
      4'h7: nv_word = cruise_ff;
      4'h8: nv_word = rup_ff;
      4'h9: nv_word = rdn_ff;
      default: nv_word = {24'h000000, mode_sel_ff};
    endcase
  end
  wire nv_last = (nv_idx_ff == `DPOB_NV_LAST);
  wire nv_load = (nv_st_ff == `DPOB_NV_LOAD) & nv_wait_ff & nv_ready;

  // ==========================================================
  // Object writes, save and power-on restore
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dspeed_ff <= `DPOB_DSPEED_RST;
      dtime_ff <= `DPOB_DTIME_RST;
      mode_sel_ff <= `DPOB_MODE_VELOCITY;
      trk_band_ff <= 32'h00000000;
      trk_delay_ff <= 32'h00000000;
      arr_band_ff <= 32'h00000000;
      arr_dwell_ff <= 32'h00000000;
      trq_set_ff <= 16'h0000;
      goal_ff <= 32'h00000000;
      zshift_ff <= 32'h00000000;
      cruise_ff <= 32'h00000000;
      rup_ff <= 32'h00000000;
      rdn_ff <= 32'h00000000;
      obj_ack <= 1'b0;
      obj_abort <= 1'b0;
      nv_st_ff <= `DPOB_NV_LOAD;
      nv_idx_ff <= 4'h0;
      nv_wait_ff <= 1'b0;
      nv_wr <= 1'b0;
      nv_rd <= 1'b0;
      nv_addr <= 4'h0;
      nv_wdata <= 32'h00000000;
    end else if (clk_en) begin
      obj_ack <= wr_en | rd_en;
      obj_abort <= 1'b0;
      nv_wr <= 1'b0;
      nv_rd <= 1'b0;
      if (wr_en) begin
        case (obj_index)
          `DPOB_IDX_QSTOP: begin
            if (obj_sub == 8'h01 && !dspeed_bad)
              dspeed_ff <= obj_wdata;
            else if (obj_sub == 8'h02 && !dtime_bad)
              dtime_ff <= obj_wdata[15:0];
            else
              obj_abort <= 1'b1;
          end
          `DPOB_IDX_MODE_SEL:
            if (mode_ok) mode_sel_ff <= obj_wdata[7:0];
          `DPOB_IDX_TRK_BAND:
            if (win_bad) obj_abort <= 1'b1;
            else trk_band_ff <= obj_wdata;
          `DPOB_IDX_TRK_DELAY: trk_delay_ff <= obj_wdata;
          `DPOB_IDX_ARR_BAND:
            if (win_bad) obj_abort <= 1'b1;
            else arr_band_ff <= obj_wdata;
          `DPOB_IDX_ARR_DWELL: arr_dwell_ff <= obj_wdata;
          `DPOB_IDX_TRQ_SET: trq_set_ff <= obj_wdata[15:0];
          `DPOB_IDX_GOAL_POS: goal_ff <= obj_wdata;
          `DPOB_IDX_ZERO_SHIFT: zshift_ff <= obj_wdata;
          `DPOB_IDX_CRUISE: cruise_ff <= obj_wdata;
          `DPOB_IDX_RAMP_UP: rup_ff <= obj_wdata;
          `DPOB_IDX_RAMP_DN: rdn_ff <= obj_wdata;
          default: obj_abort <= 1'b1;
        endcase
      end
      case (nv_st_ff)
        `DPOB_NV_IDLE: begin
          if (save_cmd && !wr_en) begin
            nv_st_ff <= `DPOB_NV_SAVE;
            nv_idx_ff <= 4'h0;
          end
        end
        `DPOB_NV_SAVE: begin
          if (nv_ready) begin
            nv_wr <= 1'b1;
            nv_addr <= nv_idx_ff;
            nv_wdata <= nv_word;
            if (nv_last) nv_st_ff <= `DPOB_NV_DONE;
            nv_idx_ff <= nv_idx_ff + 4'h1;
          end
        end
        `DPOB_NV_LOAD: begin
          if (!nv_wait_ff && nv_ready) begin
            nv_rd <= 1'b1;
            nv_addr <= nv_idx_ff;
            nv_wait_ff <= 1'b1;
          end else if (nv_load) begin
            nv_wait_ff <= 1'b0;
            case (nv_idx_ff)
              4'h0: dspeed_ff <= nv_rdata;
              4'h1: dtime_ff <= nv_rdata[15:0];
              4'h2: trk_band_ff <= nv_rdata;
              4'h3: trk_delay_ff <= nv_rdata;
              4'h4: arr_band_ff <= nv_rdata;
              4'h5: arr_dwell_ff <= nv_rdata;
              4'h6: zshift_ff <= nv_rdata;
              4'h7: cruise_ff <= nv_rdata;
              4'h8: rup_ff <= nv_rdata;
              4'h9: rdn_ff <= nv_rdata;
              default: mode_sel_ff <= nv_rdata[7:0];
            endcase
            if (nv_last) nv_st_ff <= `DPOB_NV_DONE;
            nv_idx_ff <= nv_idx_ff + 4'h1;
          end
        end
        `DPOB_NV_DONE: nv_st_ff <= `DPOB_NV_IDLE;
        default: nv_st_ff <= `DPOB_NV_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Quick stop gradient and mirrored parameters
  wire [47:0] grad_num = dspeed_ff[15:0] * {{(32-POLE_W){1'b0}}, pole_pairs};
  wire [31:0] grad = grad_num[31:0] / {16'h0000, dtime_ff};
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      estop_cw <= 32'h00000000;
      estop_acw <= 32'h00000000;
      mode_req <= `DPOB_MODE_VELOCITY;
      mode_echo_ff <= `DPOB_MODE_VELOCITY;
      contour_warn <= 32'h00000000;
      contour_time <= 32'h00000000;
      target_window <= 32'h00000000;
      target_win_time <= 32'h00000000;
      home_offset <= 32'h00000000;
      app_position <= 32'h00000000;
      torque_ref <= 16'h0000;
      torque_ref_inv <= 16'h0000;
    end else if (clk_en) begin
      estop_cw <= grad;
      estop_acw <= grad;
      mode_req <= mode_sel_ff;
      if (mode_tk_s2_ff) mode_echo_ff <= mode_req;
      contour_warn <= trk_band_ff;
      contour_time <= trk_delay_ff;
      target_window <= arr_band_ff;
      target_win_time <= arr_dwell_ff;
      home_offset <= zshift_ff;
      app_position <= pos_act_s2_ff - zshift_ff;
      torque_ref <= trq_set_ff;
      torque_ref_inv <= 16'h0000 - trq_set_ff;
    end
  end

  // ==========================================================
  // Position supervision
  reg [31:0] ms_cnt_ff;
  reg [31:0] trk_ms_ff;
  reg [31:0] arr_ms_ff;
  wire ms_tick = (ms_cnt_ff == MS_CYCLES - 1);
  wire [31:0] d_trk = pos_act_s2_ff - pos_dem_s2_ff;
  wire [31:0] a_trk = d_trk[31] ? (32'h00000000 - d_trk) : d_trk;
  wire [31:0] d_arr = app_position - goal_ff;
  wire [31:0] a_arr = d_arr[31] ? (32'h00000000 - d_arr) : d_arr;
  wire trk_on = (trk_band_ff != 32'h00000000) &
    (trk_band_ff != `DPOB_WIN_OFF);
  wire arr_on = (arr_band_ff != 32'h00000000) &
    (arr_band_ff != `DPOB_WIN_OFF);
  wire trk_err = trk_on & (a_trk > trk_band_ff);
  wire in_win = arr_on & (a_arr <= arr_band_ff);
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ms_cnt_ff <= 32'h00000000;
      trk_ms_ff <= 32'h00000000;
      arr_ms_ff <= 32'h00000000;
      status_bits <= 16'h0000;
    end else if (clk_en) begin
      ms_cnt_ff <= ms_tick ? 32'h00000000 : ms_cnt_ff + 32'h00000001;
      if (!trk_err) trk_ms_ff <= 32'h00000000;
      else if (ms_tick && trk_ms_ff <= trk_delay_ff)
        trk_ms_ff <= trk_ms_ff + 32'h00000001;
      if (!in_win) arr_ms_ff <= 32'h00000000;
      else if (ms_tick && arr_ms_ff < arr_dwell_ff)
        arr_ms_ff <= arr_ms_ff + 32'h00000001;
      status_bits[`DPOB_SW_FOLLOW_BIT] <=
        trk_err & (trk_ms_ff > trk_delay_ff);
      status_bits[`DPOB_SW_TARGET_BIT] <=
        in_win & (arr_ms_ff >= arr_dwell_ff);
    end
  end

  // ==========================================================
  // Read back
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      obj_rdata <= 32'h00000000;
    end else if (rd_en) begin
      case (obj_index)
        `DPOB_IDX_QSTOP: begin
          if (obj_sub == 8'h00) obj_rdata <= {24'h0, `DPOB_QSTOP_MAX_SUB};
          else if (obj_sub == 8'h01) obj_rdata <= dspeed_ff;
          else obj_rdata <= {16'h0000, dtime_ff};
        end
        `DPOB_IDX_MODE_SEL: obj_rdata <= {24'h000000, mode_sel_ff};
        `DPOB_IDX_MODE_ECHO: obj_rdata <= {24'h000000, mode_echo_ff};
        `DPOB_IDX_MEAS_POS: obj_rdata <= pos_act_s2_ff;
        `DPOB_IDX_TRK_BAND: obj_rdata <= trk_band_ff;
        `DPOB_IDX_TRK_DELAY: obj_rdata <= trk_delay_ff;
        `DPOB_IDX_ARR_BAND: obj_rdata <= arr_band_ff;
        `DPOB_IDX_ARR_DWELL: obj_rdata <= arr_dwell_ff;
        `DPOB_IDX_TRQ_SET: obj_rdata <= {16'h0000, trq_set_ff};
        `DPOB_IDX_MEAS_TRQ: obj_rdata <= {16'h0000, torque_pm};
        `DPOB_IDX_MEAS_CUR: obj_rdata <= {16'h0000, current_pm};
        `DPOB_IDX_BUS_MV: obj_rdata <= bus_mv;
        `DPOB_IDX_GOAL_POS: obj_rdata <= goal_ff;
        `DPOB_IDX_ZERO_SHIFT: obj_rdata <= zshift_ff;
        `DPOB_IDX_CRUISE: obj_rdata <= cruise_ff;
        `DPOB_IDX_RAMP_UP: obj_rdata <= rup_ff;
        `DPOB_IDX_RAMP_DN: obj_rdata <= rdn_ff;
        default: obj_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule

/* testbench/dpob_nv_store.sv */
// Non-volatile parameter store model
`timescale 1ns/10ps
module dpob_nv_store (
  input wire sys_clk,
  input wire nv_wr,
  input wire nv_rd,
  input wire [3:0] nv_addr,
  input wire [31:0] nv_wdata,
  output wire [31:0] nv_rdata,
  output wire nv_ready
);
  reg [31:0] mem_ff [0:15];
  reg [31:0] idle_ff;
  integer k;
  assign nv_ready = 1'b1;
  // Read word stands during the nv_rd cycle
  assign nv_rdata = nv_rd ? mem_ff[nv_addr] : idle_ff;
  initial begin
    for (k = 0; k < 16; k = k + 1) begin
      mem_ff[k] = 32'h00000000;
    end
    mem_ff[0] = 32'h00000001;
    mem_ff[1] = 32'h00000001;
    mem_ff[10] = 32'h00000002;
    idle_ff = 32'h5A5A5A5A;
  end
  // Survives reset; idle data toggles
  always @(posedge sys_clk) begin
    if (nv_wr) begin
      mem_ff[nv_addr] <= nv_wdata;
    end
    idle_ff <= ~idle_ff;
  end
endmodule

/* testbench/dpob_object_bank_monitor.sv */
// Concurrent checks on the object bank ports
`timescale 1ns/10ps
module dpob_object_bank_monitor (
  input wire sys_clk,
  input wire reset,
  input wire clk_en,
  input wire obj_wr,
  input wire obj_rd,
  input wire [15:0] obj_index,
  input wire [31:0] obj_wdata,
  input wire [31:0] obj_rdata,
  input wire obj_ack,
  input wire obj_abort,
  input wire [31:0] estop_cw,
  input wire [31:0] estop_acw,
  input wire [7:0] mode_req,
  input wire [31:0] contour_warn,
  input wire [31:0] target_window,
  input wire [15:0] status_bits,
  input wire nv_wr,
  input wire [3:0] nv_addr
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // Assertions
  a_estop_pair_equal: assert property (
    estop_cw == estop_acw) else $error("estop outputs differ");
  a_read_gets_ack: assert property (
    obj_rd && clk_en |=> obj_ack) else $error("read not acked");
  a_abort_with_ack: assert property (
    obj_abort |-> obj_ack) else $error("abort without ack");
  a_band_range_abort: assert property (
    obj_wr && clk_en && obj_index == 16'h6065 && obj_wdata[31]
    && obj_wdata != 32'hFFFFFFFF |=> !obj_ack || obj_abort)
    else $error("band overrange taken");
  a_band_mirror_warn: assert property (
    obj_wr && clk_en && obj_index == 16'h6065 && !obj_wdata[31]
    ##1 obj_ack && !obj_abort |=> contour_warn == $past(obj_wdata, 2))
    else $error("warn threshold not mirrored");
  a_mode_value_legal: assert property (
    $changed(mode_req) |-> mode_req inside {8'h01, 8'h02, 8'h06,
    8'h07, 8'hFF}) else $error("illegal mode taken");
  a_reached_needs_band: assert property (
    status_bits[10] |-> target_window != 32'h0
    && target_window != 32'hFFFFFFFF) else $error("reached while off");
  a_read_arrival_band: assert property (
    obj_rd && clk_en && !obj_wr && obj_index == 16'h6067
    |=> obj_rdata == target_window) else $error("band read mismatch");
  a_save_addr_step: assert property (
    nv_wr && nv_addr != 4'hA |=> nv_wr && nv_addr == $past(nv_addr)
    + 4'h1) else $error("save sequence broken");
  a_save_starts_zero: assert property (
    $rose(nv_wr) |-> nv_addr == 4'h0) else $error("save not at word 0");
endmodule
bind dpob_object_bank dpob_object_bank_monitor u_mon (
  .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .obj_wr(obj_wr),
  .obj_rd(obj_rd), .obj_index(obj_index), .obj_wdata(obj_wdata),
  .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_abort(obj_abort),
  .estop_cw(estop_cw), .estop_acw(estop_acw), .mode_req(mode_req),
  .contour_warn(contour_warn), .target_window(target_window),
  .status_bits(status_bits), .nv_wr(nv_wr), .nv_addr(nv_addr)
);

/* testbench/dpob_object_bank_tb.sv */
// Self-checking bench for the object bank
`timescale 1ns/10ps
`include "dpob_consts.vh"
`define CHK(n, g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
  err_total = err_total + 1; $display("BAD %s exp %h got %h", n, e, g); end end
module dpob_object_bank_tb;
  reg sys_clk, reset, clk_en, obj_wr, obj_rd, motion_cfg, mode_taken;
  reg save_cmd;
  reg [15:0] obj_index, torque_pm, current_pm;
  reg [7:0] obj_sub, pole_pairs;
  reg [31:0] obj_wdata, pos_demand, pos_actual, bus_mv;
  wire [31:0] obj_rdata, estop_cw, estop_acw, contour_warn, contour_time;
  wire [31:0] target_window, target_win_time, home_offset, app_position;
  wire [31:0] nv_wdata, nv_rdata;
  wire [15:0] torque_ref, torque_ref_inv, status_bits;
  wire [7:0] mode_req;
  wire [3:0] nv_addr;
  wire obj_ack, obj_abort, nv_wr, nv_rd, nv_ready;
  integer err_total, compares, i;
  reg [39:0] mode_list = 40'h01020607FF;
  dpob_object_bank #(.MS_CYCLES(10)) dut (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .obj_wr(obj_wr),
    .obj_rd(obj_rd), .obj_index(obj_index), .obj_sub(obj_sub),
    .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
    .obj_abort(obj_abort), .motion_cfg(motion_cfg),
    .mode_taken(mode_taken), .save_cmd(save_cmd),
    .pole_pairs(pole_pairs), .pos_demand(pos_demand),
    .pos_actual(pos_actual), .torque_pm(torque_pm),
    .current_pm(current_pm), .bus_mv(bus_mv), .estop_cw(estop_cw),
    .estop_acw(estop_acw), .mode_req(mode_req),
    .contour_warn(contour_warn), .contour_time(contour_time),
    .target_window(target_window), .target_win_time(target_win_time),
    .home_offset(home_offset), .app_position(app_position),
    .torque_ref(torque_ref), .torque_ref_inv(torque_ref_inv),
    .status_bits(status_bits), .nv_wr(nv_wr), .nv_rd(nv_rd),
    .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata),
    .nv_ready(nv_ready));
  dpob_nv_store nv (.sys_clk(sys_clk), .nv_wr(nv_wr), .nv_rd(nv_rd),
    .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata),
    .nv_ready(nv_ready));
  // ==========================================================
  // Access tasks
  task xfer(input w, input [15:0] idx, input [7:0] sub, input [31:0] d);
    begin
      @(posedge sys_clk);
      obj_wr <= w;
      obj_rd <= !w;
      obj_index <= idx;
      obj_sub <= sub;
      obj_wdata <= d;
      @(posedge sys_clk);
      obj_wr <= 1'b0;
      obj_rd <= 1'b0;
      #1;
    end
  endtask
  task wr(input [15:0] idx, input [7:0] sub, input [31:0] d, input ab);
    begin
      xfer(1'b1, idx, sub, d);
      `CHK("ack", obj_ack, 1'b1)
      `CHK("abort", obj_abort, ab)
    end
  endtask
  task rd(input [15:0] idx, input [7:0] sub, input [31:0] e);
    begin
      xfer(1'b0, idx, sub, 32'h00000000);
      `CHK("rdata", obj_rdata, e)
    end
  endtask
  task set_mode(input [7:0] m, input [7:0] e);
    begin
      wr(`DPOB_IDX_MODE_SEL, 8'h00, {24'h000000, m}, 1'b0);
      @(posedge sys_clk) mode_taken <= 1'b1;
      #1;
      `CHK("mode", mode_req, e)
      repeat (5) @(posedge sys_clk);
      xfer(1'b0, `DPOB_IDX_MODE_ECHO, 8'h00, 32'h00000000);
      `CHK("echo", obj_rdata[7:0], e)
      @(posedge sys_clk) mode_taken <= 1'b0;
    end
  endtask
  task wait_bit(input integer b, input v);
    integer n;
    begin
      n = 0;
      while (status_bits[b] !== v && n < 300) begin
        @(posedge sys_clk);
        #1;
        n = n + 1;
      end
      `CHK("status", status_bits[b], v)
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  // ==========================================================
  // Clock, watchdog, tests
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #1000000;
    err_total = err_total + 1;
    tally_and_finish;
  end
  initial begin
    err_total = 0;
    compares = 0;
    {reset, clk_en, motion_cfg} = 3'b111;
    {obj_wr, obj_rd, mode_taken, save_cmd} = 4'h0;
    {obj_index, obj_sub, obj_wdata} = 56'h0;
    {pos_demand, pos_actual} = 64'h0;
    pole_pairs = 8'h02;
    torque_pm = 16'h03E8;
    current_pm = 16'h01F4;
    bus_mv = 32'h000186A0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (40) @(posedge sys_clk);
    wr(`DPOB_IDX_TRK_BAND, 8'h00, 32'h00000037, 1'b0);
    @(posedge sys_clk) save_cmd <= 1'b1;
    @(posedge sys_clk) save_cmd <= 1'b0;
    repeat (30) @(posedge sys_clk);
    reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (40) @(posedge sys_clk);
    rd(`DPOB_IDX_TRK_BAND, 8'h00, 32'h00000037);
    wr(`DPOB_IDX_ARR_BAND, 8'h00, 32'h80000000, 1'b1);
    wr(`DPOB_IDX_ARR_BAND, 8'h00, 32'hFFFFFFFE, 1'b1);
    wr(`DPOB_IDX_TRK_BAND, 8'h00, 32'h80000000, 1'b1);
    wr(`DPOB_IDX_ARR_BAND, 8'h00, `DPOB_WIN_MAX, 1'b0);
    rd(`DPOB_IDX_ARR_BAND, 8'h00, `DPOB_WIN_MAX);
    wr(`DPOB_IDX_ARR_BAND, 8'h00, `DPOB_WIN_OFF, 1'b0);
    wr(16'h6000, 8'h00, 32'h00000001, 1'b1);
    rd(`DPOB_IDX_QSTOP, 8'h00, 32'h00000002);
    wr(`DPOB_IDX_QSTOP, 8'h01, 32'h00000064, 1'b0);
    wr(`DPOB_IDX_QSTOP, 8'h02, 32'h00000004, 1'b0);
    repeat (40) @(posedge sys_clk);
    `CHK("estop_cw", estop_cw, 32'h00000032)
    wr(`DPOB_IDX_QSTOP, 8'h01, 32'h00008000, 1'b1);
    wr(`DPOB_IDX_QSTOP, 8'h01, 32'h00000000, 1'b1);
    wr(`DPOB_IDX_QSTOP, 8'h02, 32'h00000000, 1'b1);
    wr(`DPOB_IDX_QSTOP, 8'h01, 32'h00007FFF, 1'b0);
    wr(`DPOB_IDX_QSTOP, 8'h02, 32'h00000005, 1'b0);
    repeat (40) @(posedge sys_clk);
    `CHK("estop_acw", estop_acw, 32'h00003332)
    rd(`DPOB_IDX_QSTOP, 8'h01, 32'h00007FFF);
    for (i = 0; i < 5; i = i + 1) begin
      set_mode(mode_list[39 - 8 * i -: 8], mode_list[39 - 8 * i -: 8]);
    end
    @(posedge sys_clk) motion_cfg <= 1'b0;
    repeat (5) @(posedge sys_clk);
    set_mode(`DPOB_MODE_HOMING, `DPOB_MODE_TABLE);
    set_mode(`DPOB_MODE_VELOCITY, `DPOB_MODE_VELOCITY);
    wr(`DPOB_IDX_TRK_BAND, 8'h00, 32'h0000000A, 1'b0);
    wr(`DPOB_IDX_TRK_DELAY, 8'h00, 32'h00000001, 1'b0);
    @(posedge sys_clk) pos_actual <= 32'h00000064;
    repeat (6) @(posedge sys_clk);
    `CHK("contour_time", contour_time, 32'h00000001)
    `CHK("early13", status_bits[13], 1'b0)
    wait_bit(13, 1'b1);
    @(posedge sys_clk) pos_actual <= 32'h00000005;
    wait_bit(13, 1'b0);
    wr(`DPOB_IDX_ZERO_SHIFT, 8'h00, 32'h00000064, 1'b0);
    wr(`DPOB_IDX_GOAL_POS, 8'h00, 32'h00000032, 1'b0);
    wr(`DPOB_IDX_ARR_DWELL, 8'h00, 32'h00000001, 1'b0);
    @(posedge sys_clk) pos_actual <= 32'h00000096;
    repeat (30) @(posedge sys_clk);
    `CHK("home_offset", home_offset, 32'h00000064)
    `CHK("app_position", app_position, 32'h00000032)
    `CHK("bit10_off", status_bits[10], 1'b0)
    wr(`DPOB_IDX_ARR_BAND, 8'h00, 32'h00000004, 1'b0);
    wait_bit(10, 1'b1);
    `CHK("win_time", target_win_time, 32'h00000001)
    @(posedge sys_clk) pos_actual <= 32'h000000A0;
    wait_bit(10, 1'b0);
    rd(`DPOB_IDX_MEAS_TRQ, 8'h00, 32'h000003E8);
    rd(`DPOB_IDX_MEAS_CUR, 8'h00, 32'h000001F4);
    rd(`DPOB_IDX_BUS_MV, 8'h00, 32'h000186A0);
    wr(`DPOB_IDX_TRQ_SET, 8'h00, 32'h000001F4, 1'b0);
    repeat (2) @(posedge sys_clk);
    `CHK("torque_ref", torque_ref, 16'h01F4)
    `CHK("torque_inv", torque_ref_inv, 16'hFE0C)
    @(posedge sys_clk) clk_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    xfer(1'b1, `DPOB_IDX_CRUISE, 8'h00, 32'h00005555);
    `CHK("frozen_ack", obj_ack, 1'b0)
    @(posedge sys_clk) clk_en <= 1'b1;
    rd(`DPOB_IDX_CRUISE, 8'h00, 32'h00000000);
    wr(`DPOB_IDX_CRUISE, 8'h00, 32'h00001234, 1'b0);
    rd(`DPOB_IDX_CRUISE, 8'h00, 32'h00001234);
    wr(`DPOB_IDX_RAMP_DN, 8'h00, 32'h00000321, 1'b0);
    rd(`DPOB_IDX_RAMP_DN, 8'h00, 32'h00000321);
    tally_and_finish;
  end
endmodule
